// ---- design/pwm_capture_pkg.sv ----
package pwm_capture_pkg;
    // Channel count and widths
    localparam int NUM_CH = 4;
    localparam int CNT_W = 16;
    localparam int PSC_W = 8;
    localparam int DT_W = 8;
    localparam int DIV_W = 4;
    localparam int DSEL_W = 3;
    localparam int SYNC_STAGES = 3;

    // Divider select codes
    localparam logic [DSEL_W-1:0] DIV_1 = 3'h0;
    localparam logic [DSEL_W-1:0] DIV_2 = 3'h1;
    localparam logic [DSEL_W-1:0] DIV_4 = 3'h2;
    localparam logic [DSEL_W-1:0] DIV_8 = 3'h3;
    localparam logic [DSEL_W-1:0] DIV_16 = 3'h4;

    // Capture edge select bits
    localparam int CAP_RISE_BIT = 0;
    localparam int CAP_FALL_BIT = 1;

    // Values after reset
    localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
    localparam logic [PSC_W-1:0] PSC_RST = 8'h00;
    localparam logic [DIV_W-1:0] DIV_RST = 4'h0;
    localparam logic [DT_W-1:0] DT_RST = 8'h00;
endpackage

// ---- design/cap_edge_if.sv ----
interface cap_edge_if #(
    parameter int N = 4
);
    logic [N-1:0] rise;
    logic [N-1:0] fall;

    modport src (output rise, output fall);
    modport dst (input rise, input fall);
endinterface

// ---- design/cap_pin_sync.sv ----
module cap_pin_sync #(
    parameter int N = 4
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // Capture pins
    input wire logic [N-1:0] pin_i,
    // Edge pulses
    cap_edge_if.src edge_o
);
    logic [N-1:0] s1;
    logic [N-1:0] s2;
    logic [N-1:0] s3;
    logic [N-1:0] stable;
    logic [N-1:0] rise;
    logic [N-1:0] fall;
    logic [N-1:0] next_stable;
    logic [N-1:0] next_rise;
    logic [N-1:0] next_fall;

    // Accept a change once stages two and three agree
    always_comb
    begin
        next_stable = stable;
        for (int i = 0; i < N; i++)
        begin
            if (s2[i] == s3[i])
            begin
                next_stable[i] = s3[i];
            end
        end
        next_rise = next_stable & ~stable;
        next_fall = ~next_stable & stable;
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!rstn_i)
        begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            stable <= '0;
            rise <= '0;
            fall <= '0;
        end
        else
        begin
            s1 <= pin_i;
            s2 <= s1;
            s3 <= s2;
            stable <= next_stable;
            rise <= next_rise;
            fall <= next_fall;
        end
    end

    assign edge_o.rise = rise;
    assign edge_o.fall = fall;
endmodule

// ---- design/pwm_capture_timer.sv ----
// How it works
// RL1: Four output channels, each enabled on its own.
// RL2: Each channel has a 16-bit up-counter and compare setting duty.
// RL3: Independent mode or complementary mode with inverse paired outputs.
// RL4: Complementary mode inserts an 8-bit dead-time gap between outputs.
// RL5: Every channel works as a timer with its own interrupt.
// RL6: An 8-bit prescaler divides the clock ahead of the divider.
// RL7: Divider after prescaler gives ratios 1, 2, 4, 8 or 16.
// RL8: Per-channel polarity select inverts the output waveform.
// RL9: Selected capture edge copies the counter into the capture register.
// RL10: Counter runs one-shot or auto-reload.
// RL11: Four generator interrupts, one per channel.
// RL12: Four capture inputs, each latching a 16-bit counter value.
// RL13: Four capture interrupts, one per capture channel.
// RL14: In and after reset outputs are undriven until configured.
// RL15: Outputs drive only pins whose multiplexer selects the generator.
// RL16: Output active while counter below compare, before polarity.
// RL17: Event flags stay set until cleared by writing one.
// RL18: Dead-time counts prescaled and divided counter ticks.
module pwm_capture_timer #(
    parameter int NUM_CH = pwm_capture_pkg::NUM_CH
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // Channel control
    input wire logic [NUM_CH-1:0] enable_i,
    input wire logic [NUM_CH-1:0] compl_mode_i,
    input wire logic [NUM_CH-1:0] one_shot_i,
    input wire logic [NUM_CH-1:0] invert_i,
    input wire logic [NUM_CH-1:0] pin_sel_i,
    // Channel timing
    input wire logic [NUM_CH-1:0][pwm_capture_pkg::PSC_W-1:0] prescale_i,
    input wire logic [NUM_CH-1:0][pwm_capture_pkg::DSEL_W-1:0] div_sel_i,
    input wire logic [NUM_CH-1:0][pwm_capture_pkg::CNT_W-1:0] period_i,
    input wire logic [NUM_CH-1:0][pwm_capture_pkg::CNT_W-1:0] compare_i,
    input wire logic [NUM_CH-1:0][pwm_capture_pkg::DT_W-1:0] dead_time_i,
    // Capture control
    input wire logic [NUM_CH-1:0] cap_en_i,
    input wire logic [NUM_CH-1:0][1:0] cap_edge_sel_i,
    input wire logic [NUM_CH-1:0] cap_pin_i,
    // Flag clears, write one to clear
    input wire logic [NUM_CH-1:0] gen_clr_i,
    input wire logic [NUM_CH-1:0] cap_clr_i,
    // Output pins
    output logic [NUM_CH-1:0] pwm_o,
    output logic [NUM_CH-1:0] pwm_oe_o,
    output logic [NUM_CH-1:0] pwm_n_o,
    output logic [NUM_CH-1:0] pwm_n_oe_o,
    // Status
    output logic [NUM_CH-1:0] gen_flag_o,
    output logic [NUM_CH-1:0] cap_flag_o,
    output logic [NUM_CH-1:0] running_o,
    output logic [NUM_CH-1:0][pwm_capture_pkg::CNT_W-1:0] count_o,
    output logic [NUM_CH-1:0][pwm_capture_pkg::CNT_W-1:0] capture_o
);
    typedef logic [pwm_capture_pkg::CNT_W-1:0] cnt_t;
    typedef logic [pwm_capture_pkg::PSC_W-1:0] psc_t;
    typedef logic [pwm_capture_pkg::DIV_W-1:0] div_t;
    typedef logic [pwm_capture_pkg::DT_W-1:0] dt_t;

    cap_edge_if #(.N(NUM_CH)) cap_edge ();

    psc_t [NUM_CH-1:0] psc_cnt;
    div_t [NUM_CH-1:0] div_cnt;
    cnt_t [NUM_CH-1:0] cnt;
    cnt_t [NUM_CH-1:0] cap_val;
    dt_t [NUM_CH-1:0] dt_cnt;
    logic [NUM_CH-1:0] done;
    logic [NUM_CH-1:0] raw_q;
    logic [NUM_CH-1:0] out_p;
    logic [NUM_CH-1:0] out_n;
    logic [NUM_CH-1:0] oe_p;
    logic [NUM_CH-1:0] oe_n;
    logic [NUM_CH-1:0] gen_flag;
    logic [NUM_CH-1:0] cap_flag;
    logic [NUM_CH-1:0] tick;
    logic [NUM_CH-1:0] gen_evt;
    logic [NUM_CH-1:0] running;

    psc_t [NUM_CH-1:0] next_psc_cnt;
    div_t [NUM_CH-1:0] next_div_cnt;
    cnt_t [NUM_CH-1:0] next_cnt;
    cnt_t [NUM_CH-1:0] next_cap_val;
    dt_t [NUM_CH-1:0] next_dt_cnt;
    logic [NUM_CH-1:0] next_done;
    logic [NUM_CH-1:0] next_raw_q;
    logic [NUM_CH-1:0] next_out_p;
    logic [NUM_CH-1:0] next_out_n;
    logic [NUM_CH-1:0] next_oe_p;
    logic [NUM_CH-1:0] next_oe_n;
    logic [NUM_CH-1:0] next_gen_flag;
    logic [NUM_CH-1:0] next_cap_flag;
    logic [NUM_CH-1:0] next_running;

    // Capture pin synchroniser and edge detect
    cap_pin_sync #(.N(NUM_CH)) u_sync (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .pin_i(cap_pin_i),
        .edge_o(cap_edge.src)
    );

    // Divider tap for the selected ratio
    function automatic logic div_hit(
        input div_t dc,
        input logic [pwm_capture_pkg::DSEL_W-1:0] sel
    );
        logic hit;
        case (sel)
            pwm_capture_pkg::DIV_1: hit = 1'b1;
            pwm_capture_pkg::DIV_2: hit = dc[0];
            pwm_capture_pkg::DIV_4: hit = &dc[1:0];
            pwm_capture_pkg::DIV_8: hit = &dc[2:0];
            default: hit = &dc[3:0];
        endcase
        return hit;
    endfunction

    // Time base: prescaler, divider and counter
    always_comb
    begin
        logic tick_pre;
        tick_pre = 1'b0;
        tick = '0;
        gen_evt = '0;
        next_psc_cnt = psc_cnt;
        next_div_cnt = div_cnt;
        next_cnt = cnt;
        next_done = done;
        next_running = running;
        for (int i = 0; i < NUM_CH; i++)
        begin
            tick_pre = 1'b0;
            if (!enable_i[i])
            begin
                // Disabled channel holds its time base cleared
                next_psc_cnt[i] = pwm_capture_pkg::PSC_RST; // see RL1
                next_div_cnt[i] = pwm_capture_pkg::DIV_RST;
                next_cnt[i] = pwm_capture_pkg::CNT_RST;
                next_done[i] = 1'b0;
            end
            else
            begin
                // Prescaler divides by value plus one
                tick_pre = (psc_cnt[i] == prescale_i[i]); // see RL6
                next_psc_cnt[i] = tick_pre ? pwm_capture_pkg::PSC_RST
                                           : psc_t'(psc_cnt[i] + 1'b1);
                if (tick_pre)
                begin
                    next_div_cnt[i] = div_t'(div_cnt[i] + 1'b1);
                end
                tick[i] = tick_pre
                          && div_hit(div_cnt[i], div_sel_i[i]); // see RL7
                // Counter with period end event
                if (tick[i] && !done[i])
                begin
                    if (cnt[i] == period_i[i])
                    begin
                        gen_evt[i] = 1'b1; // see RL5
                        if (one_shot_i[i])
                        begin
                            next_done[i] = 1'b1; // see RL10
                        end
                        else
                        begin
                            next_cnt[i] = pwm_capture_pkg::CNT_RST; // see RL10
                        end
                    end
                    else
                    begin
                        next_cnt[i] = cnt_t'(cnt[i] + 1'b1); // see RL2
                    end
                end
            end
            // Running until a one-shot period ends
            next_running[i] = enable_i[i] && !next_done[i]; // see RL10
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!rstn_i)
        begin
            psc_cnt <= {NUM_CH{pwm_capture_pkg::PSC_RST}};
            div_cnt <= {NUM_CH{pwm_capture_pkg::DIV_RST}};
            cnt <= {NUM_CH{pwm_capture_pkg::CNT_RST}};
            done <= '0;
            running <= '0;
        end
        else
        begin
            psc_cnt <= next_psc_cnt;
            div_cnt <= next_div_cnt;
            cnt <= next_cnt;
            done <= next_done;
            running <= next_running;
        end
    end

    // Compare, dead-time and pin drive
    always_comb
    begin
        logic raw;
        raw = 1'b0;
        next_raw_q = raw_q;
        next_dt_cnt = dt_cnt;
        next_out_p = out_p;
        next_out_n = out_n;
        next_oe_p = oe_p;
        next_oe_n = oe_n;
        for (int i = 0; i < NUM_CH; i++)
        begin
            // Compare stage
            raw = enable_i[i] && !done[i]
                  && (cnt[i] < compare_i[i]); // see RL16
            // Dead-time restarts on every raw transition
            if (raw != raw_q[i])
            begin
                next_raw_q[i] = raw;
                next_dt_cnt[i] = dead_time_i[i]; // see RL4
            end
            else if (tick[i] && dt_cnt[i] != pwm_capture_pkg::DT_RST)
            begin
                next_dt_cnt[i] = dt_t'(dt_cnt[i] - 1'b1); // see RL18
            end
            if (compl_mode_i[i])
            begin
                next_out_p[i] = (raw_q[i] && dt_cnt[i] == '0) ^ invert_i[i];
                next_out_n[i] = (!raw_q[i] && dt_cnt[i] == '0)
                                ^ invert_i[i]; // see RL3
            end
            else
            begin
                next_out_p[i] = raw ^ invert_i[i]; // see RL8
                next_out_n[i] = invert_i[i];
            end
            // Pins driven only when enabled and selected
            next_oe_p[i] = enable_i[i] && pin_sel_i[i]; // see RL15
            next_oe_n[i] = enable_i[i] && pin_sel_i[i]
                           && compl_mode_i[i]; // see RL14
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!rstn_i)
        begin
            dt_cnt <= {NUM_CH{pwm_capture_pkg::DT_RST}};
            raw_q <= '0;
            out_p <= '0;
            out_n <= '0;
            oe_p <= '0; // see RL14
            oe_n <= '0;
        end
        else
        begin
            dt_cnt <= next_dt_cnt;
            raw_q <= next_raw_q;
            out_p <= next_out_p;
            out_n <= next_out_n;
            oe_p <= next_oe_p;
            oe_n <= next_oe_n;
        end
    end

    // Capture and sticky flags
    always_comb
    begin
        logic cap_evt;
        cap_evt = 1'b0;
        next_cap_val = cap_val;
        next_gen_flag = gen_flag;
        next_cap_flag = cap_flag;
        for (int i = 0; i < NUM_CH; i++)
        begin
            // Capture on chosen edge
            cap_evt = cap_en_i[i]
                && ((cap_edge_sel_i[i][pwm_capture_pkg::CAP_RISE_BIT]
                     && cap_edge.rise[i])
                 || (cap_edge_sel_i[i][pwm_capture_pkg::CAP_FALL_BIT]
                     && cap_edge.fall[i]));
            if (cap_evt)
            begin
                next_cap_val[i] = cnt[i]; // see RL9
            end
            // Sticky flags, set beats clear
            next_gen_flag[i] = (gen_flag[i] && !gen_clr_i[i])
                               || gen_evt[i]; // see RL11, RL17
            next_cap_flag[i] = (cap_flag[i] && !cap_clr_i[i])
                               || cap_evt; // see RL13
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!rstn_i)
        begin
            cap_val <= {NUM_CH{pwm_capture_pkg::CNT_RST}}; // see RL12
            gen_flag <= '0; // see RL17
            cap_flag <= '0;
        end
        else
        begin
            cap_val <= next_cap_val;
            gen_flag <= next_gen_flag;
            cap_flag <= next_cap_flag;
        end
    end

    // Outputs
    assign pwm_o = out_p;
    assign pwm_n_o = out_n;
    assign pwm_oe_o = oe_p;
    assign pwm_n_oe_o = oe_n;
    assign gen_flag_o = gen_flag;
    assign cap_flag_o = cap_flag;
    assign running_o = running;
    assign count_o = cnt;
    assign capture_o = cap_val;
endmodule

// ---- dv/pwm_capture_timer_checker.sv ----
module pwm_capture_timer_checker #(
    parameter int NUM_CH = 4
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // Controls
    input wire logic [NUM_CH-1:0] enable_i,
    input wire logic [NUM_CH-1:0] compl_mode_i,
    input wire logic [NUM_CH-1:0] invert_i,
    input wire logic [NUM_CH-1:0] pin_sel_i,
    input wire logic [NUM_CH-1:0] gen_clr_i,
    // Outputs
    input wire logic [NUM_CH-1:0] pwm_o,
    input wire logic [NUM_CH-1:0] pwm_oe_o,
    input wire logic [NUM_CH-1:0] pwm_n_o,
    input wire logic [NUM_CH-1:0] pwm_n_oe_o,
    input wire logic [NUM_CH-1:0] gen_flag_o,
    input wire logic [NUM_CH-1:0][pwm_capture_pkg::CNT_W-1:0] count_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk_i);
    endclocking
    default disable iff (!rstn_i);
    sequence idle_s;
        (!enable_i[0] && !compl_mode_i[0] && $stable(invert_i[0]))[*3];
    endsequence
    sequence moved_s;
        count_o[0] != $past(count_o[0]);
    endsequence
    reset_quiet_a: assert property (
        $rose(rstn_i) |-> !(|{pwm_oe_o, pwm_n_oe_o, count_o[0]}))
        else $error("pins driven just after reset");
    oe_gate_a: assert property (
        !(|(pwm_oe_o & ~$past(enable_i & pin_sel_i))))
        else $error("output enable without pin select");
    noe_gate_a: assert property (
        !(|(pwm_n_oe_o & ~$past(enable_i & pin_sel_i & compl_mode_i))))
        else $error("paired enable outside complementary mode");
    flag_hold_a: assert property (
        &(gen_flag_o | ~($past(gen_flag_o) & ~$past(gen_clr_i))))
        else $error("flag dropped without clear");
    clear_count_a: assert property (
        !enable_i[0] |=> count_o[0] == 16'h0000)
        else $error("counter kept value while disabled");
    count_step_a: assert property (
        moved_s |-> count_o[0] == 16'($past(count_o[0]) + 16'h0001)
        || count_o[0] == 16'h0000)
        else $error("counter skipped a value");
    idle_level_a: assert property (
        idle_s |-> pwm_o[0] == invert_i[0])
        else $error("idle level ignores polarity");
    no_overlap_a: assert property (
        compl_mode_i[0] && $past(compl_mode_i[0]) && $stable(invert_i[0])
        |-> !((pwm_o[0] ^ invert_i[0]) && (pwm_n_o[0] ^ invert_i[0])))
        else $error("both paired outputs active");
endmodule
bind pwm_capture_timer pwm_capture_timer_checker #(.NUM_CH(NUM_CH)) chk_u (
    .sys_clk_i, .rstn_i, .enable_i, .compl_mode_i, .invert_i, .pin_sel_i,
    .gen_clr_i, .pwm_o, .pwm_oe_o, .pwm_n_o, .pwm_n_oe_o, .gen_flag_o,
    .count_o);

// ---- dv/pin_load_model.sv ----
module pin_load_model (
    // Generator pins
    input wire logic [3:0] pwm_i,
    input wire logic [3:0] pwm_oe_i,
    // Capture source
    input wire logic [3:0] cap_req_i,
    // Pin levels
    output logic [3:0] line_o,
    output logic [3:0] cap_pin_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Undriven pins rest at the weak pull-up
    assign line_o = (pwm_i & pwm_oe_i) | ~pwm_oe_i;
    // Capture wire, unrelated to the clock
    assign #1 cap_pin_o = cap_req_i;
endmodule

// ---- dv/pwm_capture_timer_tb_top.sv ----
module pwm_capture_timer_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [3:0] en, cm, os, inv, ps, cen, gclr, cclr, creq, cpin, line;
    logic [3:0][7:0] psc, dt;
    logic [3:0][2:0] dsel;
    logic [3:0][15:0] per, cmp, cnt, capv;
    logic [3:0][1:0] esel;
    logic [3:0] pwm, pwm_oe, pwm_n, pwm_n_oe, gflag, cflag, run;
    int failures = 0;
    int n_tests = 0;
    int cycles = 0;
    logic [31:0] seed = 32'h79f6;
    pwm_capture_timer dut_u (
        .sys_clk_i, .rstn_i, .enable_i(en), .compl_mode_i(cm),
        .one_shot_i(os), .invert_i(inv), .pin_sel_i(ps),
        .prescale_i(psc), .div_sel_i(dsel), .period_i(per),
        .compare_i(cmp), .dead_time_i(dt), .cap_en_i(cen),
        .cap_edge_sel_i(esel), .cap_pin_i(cpin), .gen_clr_i(gclr),
        .cap_clr_i(cclr), .pwm_o(pwm), .pwm_oe_o(pwm_oe),
        .pwm_n_o(pwm_n), .pwm_n_oe_o(pwm_n_oe), .gen_flag_o(gflag),
        .cap_flag_o(cflag), .running_o(run), .count_o(cnt),
        .capture_o(capv));
    pin_load_model load_u (.pwm_i(pwm), .pwm_oe_i(pwm_oe),
        .cap_req_i(creq), .line_o(line), .cap_pin_o(cpin));
    always #2 sys_clk_i = ~sys_clk_i;
    function automatic int rnd(input int m);
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return int'(seed[15:0]) % m;
    endfunction
    function automatic int tick_len(input int p, input int d);
        return (p + 1) << (d > 4 ? 4 : d);
    endfunction
    task automatic chk(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected %s: expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    always @(posedge sys_clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            close_out();
        end
    end
    task automatic clk_n(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask
    task automatic start(input logic o, input int p, input int c);
        @(posedge sys_clk_i);
        en[0] <= 1'b0;
        os[0] <= o;
        per[0] <= 16'(p);
        cmp[0] <= 16'(c);
        @(posedge sys_clk_i);
        en[0] <= 1'b1;
    endtask
    task automatic clear_flags();
        @(posedge sys_clk_i);
        {gclr, cclr} <= 8'hff;
        @(posedge sys_clk_i);
        {gclr, cclr} <= 8'h00;
    endtask
    task automatic wait_move(output int n);
        logic [15:0] v;
        #1;
        v = cnt[0];
        n = 0;
        do
        begin
            clk_n(1);
            n++;
        end
        while (cnt[0] === v && n < 600);
    endtask
    task automatic duty(output int hi, output int gp, input int len);
        hi = 0;
        gp = 0;
        repeat (len)
        begin
            clk_n(1);
            hi += int'(pwm[0] === 1'b1);
            gp += int'(pwm[0] === inv[0] && pwm_n[0] === inv[0]);
        end
    endtask
    initial
    begin
        int n, hi, gp, p, c;
        {en, cm, os, inv, ps, cen, gclr, cclr, creq, psc, dt} = '0;
        {dsel, per, cmp, esel} = '0;
        repeat (3) @(posedge sys_clk_i);
        rstn_i <= 1'b1;
        clk_n(1);
        chk("oe after reset", 32'h0, {pwm_oe, pwm_n_oe});
        chk("count after reset", 32'h0, cnt[0]);
        ps <= 4'hf;
        os <= 4'hf;
        per <= {4{16'h0001}};
        for (int k = 0; k < 4; k++)
        begin
            @(posedge sys_clk_i);
            en <= 4'(1 << k);
            clk_n(8);
            chk("gen flag", 1 << k, gflag);
            chk("running", 32'h0, run);
            @(posedge sys_clk_i);
            en <= 4'h0;
            clear_flags();
            clk_n(1);
            chk("flag cleared", 32'h0, gflag);
        end
        start(1'b1, 2, 1);
        clk_n(10);
        chk("one shot count", 32'h2, cnt[0]);
        chk("one shot flag", 32'h2, {gflag[0], run[0]});
        for (int d = 0; d < 7; d++)
        begin
            p = (d == 6) ? 255 : rnd(4);
            psc[0] <= 8'(p);
            dsel[0] <= 3'(d == 6 ? 0 : d);
            start(1'b0, 65535, 0);
            wait_move(n);
            wait_move(n);
            chk("tick gap", tick_len(p, d == 6 ? 0 : d), n);
        end
        {psc[0], dsel[0]} <= 11'h000;
        for (int i = 0; i < 4; i++)
        begin
            p = 4 + rnd(12);
            c = rnd(p + 3);
            inv[0] <= i[0];
            ps[0] <= i[1];
            start(1'b0, p, c);
            clk_n(4);
            duty(hi, gp, p + 1);
            c = c > p ? p + 1 : c;
            chk("high cycles", i[0] ? p + 1 - c : c, hi);
            chk("pin enable", i[1], pwm_oe[0]);
            chk("running", 32'h1, run[0]);
            if (!i[1])
                chk("pin pulled up", 32'h1, line[0]);
        end
        inv[0] <= 1'b0;
        cm[0] <= 1'b1;
        for (int j = 0; j < 2; j++)
        begin
            n = j * (1 + rnd(3));
            dt[0] <= 8'(n);
            start(1'b0, 19, 10);
            clk_n(8);
            duty(hi, gp, 20);
            chk("paired enable", 32'h1, pwm_n_oe[0]);
            chk("dead gap", 2 * n, gp);
        end
        cm[0] <= 1'b0;
        start(1'b1, 5, 0);
        clk_n(12);
        for (int s = 0; s < 5; s++)
        begin
            cen[0] <= s < 4;
            esel[0] <= 2'(s == 4 ? 3 : s);
            clear_flags();
            creq[0] <= 1'b1;
            clk_n(8);
            chk("rise capture", s < 4 && s[0], cflag[0]);
            clear_flags();
            creq[0] <= 1'b0;
            clk_n(8);
            chk("fall capture", s < 4 && s[1], cflag[0]);
        end
        chk("capture value", 32'h5, capv[0]);
        close_out();
    end
endmodule
